// >>> core/adcpd_pkg.sv
// Constants shared by the converter end and the serial master end.
// Assumes one 200 MHz system clock in both ends.
package adcpd_pkg;
  localparam int CLK_PERIOD_NS = 5;
  // Mode-bit pair decode.
  localparam logic [1:0] MODE_EXT = 2'h3;
  localparam logic [1:0] MODE_INT = 2'h2;
  localparam logic [1:0] MODE_QUICK = 2'h1;
  localparam logic [1:0] MODE_DEEP = 2'h0;
  localparam int CTRL_BITS = 8;
  localparam int RESULT_BITS = 12;
  localparam int FRAME_BITS = 24;
  // Result bits shown before a new start bit is taken (bits 11 down to 5).
  localparam logic [3:0] EARLY_START_BITS = 4'h7;
  // Longest internal conversion, rounded down.
  localparam int T_INT_CONV_NS = 10000;
  localparam int INT_CONV_CYC = T_INT_CONV_NS / CLK_PERIOD_NS;
  // Least power-up waits, rounded up.
  localparam int T_WAKE_QUICK_NS = 5000;
  localparam int T_WAKE_DEEP_NS = 300000;
  localparam int T_WAKE_NOBUF_NS = 2000;
  localparam int T_WAKE_EXTCOMP_NS = 20000000;
  localparam int WAKE_QUICK_CYC = (T_WAKE_QUICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WAKE_DEEP_CYC = (T_WAKE_DEEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WAKE_NOBUF_CYC = (T_WAKE_NOBUF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WAKE_EXTCOMP_CYC = (T_WAKE_EXTCOMP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [6:0] IDLE_CLOCKS = 7'h4b;
  // Register map of the master, byte addresses.
  localparam logic [3:0] REG_CMD = 4'h0;
  localparam logic [3:0] REG_CFG = 4'h4;
  localparam logic [3:0] REG_STATUS = 4'h8;
  localparam logic [3:0] REG_RESULT = 4'hc;
  localparam int CFG_NOBUF_BIT = 2;
  localparam logic [2:0] CFG_RESET = 3'h2;
  localparam logic [1:0] HARD_SHUTDOWN_INPUT_LOW = 2'h0;
  localparam logic [1:0] HARD_SHUTDOWN_INPUT_FLOAT = 2'h1;
  localparam logic [1:0] HARD_SHUTDOWN_INPUT_HIGH = 2'h2;
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_SETTLED_BIT = 1;
  localparam int ST_STROBE_BIT = 2;
  typedef enum logic [1:0] {PWR_AWAKE, PWR_QUICK, PWR_DEEP} adcpd_power_e;
endpackage

// >>> core/adcpd_if.sv
// Serial link between the converter end and the master end.
// The two-way pins carry value and enable apart; the converter end decodes the shutdown pin from both.
interface adcpd_if;
  logic sclk;
  logic cs_n;
  logic din;
  logic hard_shutdown_input;
  logic hard_shutdown_input_oe;
  logic dout;
  logic dout_oe;
  logic conversion_strobe_output;
  logic conversion_strobe_output_oe;
  modport dev (
    input sclk, cs_n, din, hard_shutdown_input, hard_shutdown_input_oe,
    output dout, dout_oe, conversion_strobe_output, conversion_strobe_output_oe
  );
  modport host (
    output sclk, cs_n, din, hard_shutdown_input, hard_shutdown_input_oe,
    input dout, dout_oe, conversion_strobe_output, conversion_strobe_output_oe
  );
endinterface

// >>> core/adcpd_device.sv
// Converter end: serial control byte, clock modes, power-down control.
// Assumes link pins come from another domain; the sample code is steady.
// Behaviour
// - Host selects power-down through control-byte last bits.
// - Mode pairs 11 ext, 10 int, 01 quick, 00 deep.
// - Shutdown input low forces complete shutdown.
// - Software shutdown waits for current conversion end.
// - Sleeping keeps serial interface, performs no conversion.
// - Internal-mode result still shifts out while asleep.
// - First one on data input starts and wakes.
// - Upper mode bit zero sleeps after one conversion.
// - Hardware shutdown aborts conversion, enters deep sleep.
// - Shutdown high internal, floating external, low off.
// - Host waits documented power-up delays; the master only counts them down and flags settled in status.
// - External compensation needs about 20 ms warm-up.
// - Quick sleep external: dummy, 75 idle clocks.
// - Spend reference settling in quick sleep.
// - Results are 12-bit binary codes.
// - Conversion starts on falling edge after bit eight.
// - Power-on comes up internal mode, strobe high.
// - Start taken when idle or after bit five.
module adcpd_device #(
  parameter int INT_CONV_CYCLES = adcpd_pkg::INT_CONV_CYC
) (
  // Clock and reset
  input wire logic I_CLOCK,
  input wire logic I_RESET,
  // Serial link
  adcpd_if.dev LINK,
  // Analog front end
  input wire logic [11:0] I_SAMPLE_CODE,
  // Status
  output logic [1:0] O_MODE,
  output logic [1:0] O_POWER,
  output logic O_COMP_INTERNAL,
  output logic O_CONVERTING
);
  initial begin
    if (INT_CONV_CYCLES < 1 || INT_CONV_CYCLES > 65535) begin
      $error("INT_CONV_CYCLES out of range");
    end
  end

  typedef enum logic [1:0] {CV_IDLE, CV_EXT, CV_INT} adcpd_conv_e;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: a change counts once the second and third stages agree.
  logic [4:0] raw;
  logic [4:0] s1_q, s2_q, s3_q, st_q, st_d;
  logic sclk_rise, sclk_fall, cs_low, din_s, hard_shutdown_input_low;
  assign raw = {LINK.sclk, LINK.cs_n, LINK.din, LINK.hard_shutdown_input, LINK.hard_shutdown_input_oe};
  always_ff @(posedge I_CLOCK or posedge I_RESET) begin
    if (I_RESET) begin
      s1_q <= 5'h0a;
      s2_q <= 5'h0a;
      s3_q <= 5'h0a;
      st_q <= 5'h0a;
    end else begin
      s1_q <= raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
      st_q <= st_d;
    end
  end
  assign st_d = (st_q & (s2_q ^ s3_q)) | (s3_q & ~(s2_q ^ s3_q));
  assign sclk_rise = st_d[4] & ~st_q[4];
  assign sclk_fall = ~st_d[4] & st_q[4];
  assign cs_low = ~st_q[3];
  assign din_s = st_q[2];
  assign hard_shutdown_input_low = st_q[0] & ~st_q[1];
  assign O_COMP_INTERNAL = st_q[0] & st_q[1];

  ////////////////////////////////////////////////////////////////////////////
  // Control-byte receiver.
  logic [3:0] rx_cnt_q;
  logic [6:0] rx_sh_q;
  logic [1:0] mode_q;
  logic clk_ext_q, pending_q, start_ok, byte_done, start_bit;
  adcpd_conv_e cv_q;
  adcpd_pkg::adcpd_power_e pwr_q;
  logic [3:0] shown_q;
  logic shift_q;
  assign start_ok = cs_low & ~hard_shutdown_input_low &
    (cv_q == CV_IDLE || (shift_q && shown_q >= adcpd_pkg::EARLY_START_BITS));
  assign start_bit = sclk_rise & rx_cnt_q == 4'h0 & din_s & start_ok;
  assign byte_done = sclk_rise & cs_low & ~hard_shutdown_input_low & rx_cnt_q == 4'h7;
  always_ff @(posedge I_CLOCK or posedge I_RESET) begin
    if (I_RESET) begin
      rx_cnt_q <= 4'h0;
      rx_sh_q <= 7'h00;
    end else if (~cs_low || hard_shutdown_input_low) begin
      rx_cnt_q <= 4'h0;
    end else if (start_bit) begin
      rx_cnt_q <= 4'h1;
    end else if (sclk_rise && rx_cnt_q != 4'h0) begin
      rx_sh_q <= {rx_sh_q[5:0], din_s};
      rx_cnt_q <= byte_done ? 4'h0 : rx_cnt_q + 4'h1;
    end
  end

  // Mode pair and the clock mode used by the next conversion.
  always_ff @(posedge I_CLOCK or posedge I_RESET) begin
    if (I_RESET) begin
      mode_q <= adcpd_pkg::MODE_INT;
      clk_ext_q <= 1'b0;
    end else if (hard_shutdown_input_low) begin
      mode_q <= adcpd_pkg::MODE_DEEP;
    end else if (byte_done) begin
      mode_q <= {rx_sh_q[0], din_s};
      if (rx_sh_q[0]) begin
        clk_ext_q <= din_s;
      end
    end
  end
  assign O_MODE = mode_q;

  always_ff @(posedge I_CLOCK or posedge I_RESET) begin
    if (I_RESET) begin
      pending_q <= 1'b0;
    end else if (hard_shutdown_input_low || sclk_fall) begin
      pending_q <= 1'b0;
    end else if (byte_done) begin
      pending_q <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Conversion, strobe and result shifter.
  logic [11:0] res_q;
  logic [15:0] int_cnt_q;
  logic conversion_strobe_output_q, dout_q, conv_start, conv_done;
  assign conv_start = sclk_fall & pending_q & pwr_q == adcpd_pkg::PWR_AWAKE;
  assign conv_done = (cv_q == CV_EXT && sclk_fall && shift_q && shown_q == 4'hb) ||
    (cv_q == CV_INT && int_cnt_q == 16'h0000);
  always_ff @(posedge I_CLOCK or posedge I_RESET) begin
    if (I_RESET) begin
      cv_q <= CV_IDLE;
      int_cnt_q <= 16'h0000;
    end else if (hard_shutdown_input_low) begin
      cv_q <= CV_IDLE;
    end else if (conv_start) begin
      cv_q <= clk_ext_q ? CV_EXT : CV_INT;
      int_cnt_q <= 16'(INT_CONV_CYCLES - 1);
    end else if (conv_done) begin
      cv_q <= CV_IDLE;
    end else if (cv_q == CV_INT) begin
      int_cnt_q <= int_cnt_q - 16'h0001;
    end
  end
  assign O_CONVERTING = cv_q != CV_IDLE;

  always_ff @(posedge I_CLOCK or posedge I_RESET) begin
    if (I_RESET) begin
      conversion_strobe_output_q <= 1'b1;
    end else if (conv_start) begin
      conversion_strobe_output_q <= clk_ext_q;
    end else if (cv_q == CV_EXT && sclk_fall) begin
      conversion_strobe_output_q <= 1'b0;
    end else if (cv_q == CV_INT && conv_done) begin
      conversion_strobe_output_q <= 1'b1;
    end
  end

  // The result shifter runs on the serial clock alone, so it keeps working in sleep.
  always_ff @(posedge I_CLOCK or posedge I_RESET) begin
    if (I_RESET) begin
      res_q <= 12'h000;
      shift_q <= 1'b0;
      shown_q <= 4'h0;
      dout_q <= 1'b0;
    end else if (hard_shutdown_input_low) begin
      shift_q <= 1'b0;
      dout_q <= 1'b0;
    end else if (conv_start) begin
      res_q <= I_SAMPLE_CODE;
      shift_q <= clk_ext_q;
      shown_q <= 4'h0;
    end else if (cv_q == CV_INT && conv_done) begin
      shift_q <= 1'b1;
    end else if (sclk_fall) begin
      dout_q <= shift_q & res_q[11];
      if (shift_q) begin
        res_q <= {res_q[10:0], 1'b0};
        shown_q <= shown_q + 4'h1;
        shift_q <= shown_q != 4'hb;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Power state.
  always_ff @(posedge I_CLOCK or posedge I_RESET) begin
    if (I_RESET) begin
      pwr_q <= adcpd_pkg::PWR_AWAKE;
    end else if (hard_shutdown_input_low) begin
      pwr_q <= adcpd_pkg::PWR_DEEP;
    end else if (start_bit) begin
      pwr_q <= adcpd_pkg::PWR_AWAKE;
    end else if (conv_done && !mode_q[1]) begin
      pwr_q <= mode_q[0] ? adcpd_pkg::PWR_QUICK : adcpd_pkg::PWR_DEEP;
    end
  end
  assign O_POWER = pwr_q;

  assign LINK.dout = dout_q;
  assign LINK.dout_oe = cs_low & ~hard_shutdown_input_low;
  assign LINK.conversion_strobe_output = conversion_strobe_output_q;
  assign LINK.conversion_strobe_output_oe = ~hard_shutdown_input_low & (cs_low | ~clk_ext_q);
endmodule

// >>> core/adcpd_host.sv
// Master end: Avalon-MM slave for software, serial master on the link.
// Assumes link inputs come from another domain.
module adcpd_host #(
  parameter int HALF_CYCLES = 8,
  parameter int WAKE_DEEP_CYCLES = adcpd_pkg::WAKE_DEEP_CYC,
  parameter int WAKE_EXT_CYCLES = adcpd_pkg::WAKE_EXTCOMP_CYC
) (
  // Clock and reset
  input wire logic I_CLOCK,
  input wire logic I_RESET,
  // Avalon-MM slave
  input wire logic [3:0] I_AVS_ADDRESS,
  input wire logic I_AVS_READ,
  input wire logic I_AVS_WRITE,
  input wire logic [31:0] I_AVS_WRITEDATA,
  output logic [31:0] O_AVS_READDATA,
  output logic O_AVS_WAITREQUEST,
  // Serial link
  adcpd_if.host LINK
);
  initial begin
    if (HALF_CYCLES < 8 || HALF_CYCLES > 255) begin
      $error("HALF_CYCLES out of range");
    end
  end

  typedef enum logic [1:0] {H_IDLE, H_SHIFT, H_STROBE, H_IDLE_CLK} adcpd_host_e;

  ////////////////////////////////////////////////////////////////////////////
  // Synchronisers for dout and strobe.
  logic [1:0] s1_q, s2_q, s3_q, st_q;
  always_ff @(posedge I_CLOCK or posedge I_RESET) begin
    if (I_RESET) begin
      s1_q <= 2'h0;
      s2_q <= 2'h0;
      s3_q <= 2'h0;
      st_q <= 2'h0;
    end else begin
      s1_q <= {LINK.dout, LINK.conversion_strobe_output};
      s2_q <= s1_q;
      s3_q <= s2_q;
      st_q <= (st_q & (s2_q ^ s3_q)) | (s3_q & ~(s2_q ^ s3_q));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register access, one wait cycle per access; a command write waits longer while the master is busy.
  adcpd_host_e st_h_q;
  logic ack_q, stall, done, wr_cmd;
  logic [2:0] cfg_q;
  logic [11:0] result_q;
  logic [31:0] rdata_q;
  logic [24:0] settle_q;
  logic settled;
  assign stall = I_AVS_WRITE & I_AVS_ADDRESS == adcpd_pkg::REG_CMD & st_h_q != H_IDLE;
  assign O_AVS_WAITREQUEST = (I_AVS_READ | I_AVS_WRITE) & ~ack_q;
  assign done = (I_AVS_READ | I_AVS_WRITE) & ack_q;
  assign wr_cmd = done & I_AVS_WRITE & I_AVS_ADDRESS == adcpd_pkg::REG_CMD;
  assign settled = settle_q == 25'h0 && st_h_q != H_IDLE_CLK;
  always_ff @(posedge I_CLOCK or posedge I_RESET) begin
    if (I_RESET) begin
      ack_q <= 1'b0;
      rdata_q <= 32'h0;
    end else begin
      ack_q <= (I_AVS_READ | I_AVS_WRITE) & ~ack_q & ~stall;
      unique case (I_AVS_ADDRESS)
        adcpd_pkg::REG_CFG: rdata_q <= {29'h0, cfg_q};
        adcpd_pkg::REG_STATUS: rdata_q <= {29'h0, st_q[0], settled, st_h_q != H_IDLE};
        adcpd_pkg::REG_RESULT: rdata_q <= {20'h0, result_q};
        default: rdata_q <= 32'h0;
      endcase
    end
  end
  assign O_AVS_READDATA = rdata_q;

  always_ff @(posedge I_CLOCK or posedge I_RESET) begin
    if (I_RESET) begin
      cfg_q <= adcpd_pkg::CFG_RESET;
    end else if (done && I_AVS_WRITE && I_AVS_ADDRESS == adcpd_pkg::REG_CFG) begin
      cfg_q <= I_AVS_WRITEDATA[2:0];
    end
  end
  assign LINK.hard_shutdown_input = cfg_q[1];
  assign LINK.hard_shutdown_input_oe = cfg_q[1:0] != adcpd_pkg::HARD_SHUTDOWN_INPUT_FLOAT;

  ////////////////////////////////////////////////////////////////////////////
  // Serial master.
  logic [7:0] div_q, tx_q;
  logic [4:0] bit_q;
  logic [6:0] idle_q;
  logic [23:0] rx_q;
  logic tick, sclk_q, cs_n_q, din_q, ext_mode_q, wake_q, strobe_low_q;
  adcpd_pkg::adcpd_power_e slp_q;
  assign tick = div_q == 8'(HALF_CYCLES - 1);
  always_ff @(posedge I_CLOCK or posedge I_RESET) begin
    if (I_RESET) begin
      div_q <= 8'h00;
    end else begin
      div_q <= (tick || st_h_q == H_IDLE || st_h_q == H_STROBE) ? 8'h00 : div_q + 8'h01;
    end
  end

  always_ff @(posedge I_CLOCK or posedge I_RESET) begin
    if (I_RESET) begin
      st_h_q <= H_IDLE;
      sclk_q <= 1'b0;
      cs_n_q <= 1'b1;
      din_q <= 1'b0;
      tx_q <= 8'h00;
      bit_q <= 5'h00;
      rx_q <= 24'h0;
      idle_q <= 7'h00;
      result_q <= 12'h000;
      strobe_low_q <= 1'b0;
    end else begin
      unique case (st_h_q)
        H_IDLE: if (wr_cmd) begin
          st_h_q <= H_SHIFT;
          cs_n_q <= 1'b0;
          tx_q <= I_AVS_WRITEDATA[7:0];
          din_q <= I_AVS_WRITEDATA[7];
          bit_q <= 5'h00;
        end
        H_SHIFT: if (tick && !sclk_q) begin
          sclk_q <= 1'b1;
        end else if (tick) begin
          // Sample just before the fall: the bit shown on the previous fall has crossed
          // both synchronisers by now, which a sample at the rise cannot promise.
          sclk_q <= 1'b0;
          rx_q <= {rx_q[22:0], st_q[1]};
          bit_q <= bit_q + 5'h01;
          din_q <= tx_q[6];
          tx_q <= {tx_q[6:0], 1'b0};
          if (bit_q == 5'h07 && !ext_mode_q && wake_q) begin
            st_h_q <= H_STROBE;
            strobe_low_q <= 1'b0;
          end else if (bit_q == 5'(adcpd_pkg::FRAME_BITS - 1)) begin
            cs_n_q <= 1'b1;
            result_q <= rx_q[13:2];
            idle_q <= adcpd_pkg::IDLE_CLOCKS;
            st_h_q <= (wake_q && slp_q == adcpd_pkg::PWR_QUICK &&
              cfg_q[1:0] == adcpd_pkg::HARD_SHUTDOWN_INPUT_FLOAT) ? H_IDLE_CLK : H_IDLE;
          end
        end
        H_STROBE: begin
          // The strobe may still stand high from the last conversion, so its rise
          // counts only after it has been seen low.
          if (!st_q[0]) begin
            strobe_low_q <= 1'b1;
          end
          if (st_q[0] && strobe_low_q && div_q == 8'h00) begin
            st_h_q <= H_SHIFT;
          end
        end
        H_IDLE_CLK: if (tick) begin
          sclk_q <= ~sclk_q;
          if (sclk_q) begin
            idle_q <= idle_q - 7'h01;
            st_h_q <= idle_q == 7'h01 ? H_IDLE : H_IDLE_CLK;
          end
        end
      endcase
    end
  end
  assign LINK.sclk = sclk_q;
  assign LINK.cs_n = cs_n_q;
  assign LINK.din = din_q;

  // Track the converter's clock mode and sleep state for the power-up waits.
  always_ff @(posedge I_CLOCK or posedge I_RESET) begin
    if (I_RESET) begin
      ext_mode_q <= 1'b0;
      slp_q <= adcpd_pkg::PWR_AWAKE;
      wake_q <= 1'b0;
      settle_q <= 25'h0;
    end else if (cfg_q[1:0] == adcpd_pkg::HARD_SHUTDOWN_INPUT_LOW) begin
      slp_q <= adcpd_pkg::PWR_DEEP;
      wake_q <= 1'b0;
    end else if (wr_cmd && st_h_q == H_IDLE) begin
      wake_q <= I_AVS_WRITEDATA[7];
      if (I_AVS_WRITEDATA[7]) begin
        if (I_AVS_WRITEDATA[1]) begin
          ext_mode_q <= I_AVS_WRITEDATA[0];
        end
        if (slp_q != adcpd_pkg::PWR_AWAKE) begin
          if (cfg_q[adcpd_pkg::CFG_NOBUF_BIT]) begin
            settle_q <= 25'(adcpd_pkg::WAKE_NOBUF_CYC);
          end else if (cfg_q[1:0] == adcpd_pkg::HARD_SHUTDOWN_INPUT_FLOAT) begin
            settle_q <= slp_q == adcpd_pkg::PWR_DEEP ? 25'(WAKE_EXT_CYCLES) : 25'h0;
          end else begin
            settle_q <= slp_q == adcpd_pkg::PWR_DEEP ? 25'(WAKE_DEEP_CYCLES) :
              25'(adcpd_pkg::WAKE_QUICK_CYC);
          end
        end
        slp_q <= I_AVS_WRITEDATA[1] ? adcpd_pkg::PWR_AWAKE :
          (I_AVS_WRITEDATA[0] ? adcpd_pkg::PWR_QUICK : adcpd_pkg::PWR_DEEP);
      end
    end else if (settle_q != 25'h0) begin
      settle_q <= settle_q - 25'h1;
    end
  end
endmodule

// >>> tb/adcpd_properties.sv
// Concurrent checks on the serial link and the converter status outputs.
// Assumes one clock domain and the link signals taken straight from the interface.
module adcpd_properties (
  // Clock and reset
  input wire logic I_CLOCK,
  input wire logic I_RESET,
  // Link signals
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic din,
  input wire logic hard_shutdown_input,
  input wire logic hard_shutdown_input_oe,
  input wire logic dout,
  input wire logic dout_oe,
  input wire logic conversion_strobe_output,
  input wire logic conversion_strobe_output_oe,
  // Converter status
  input wire logic [1:0] O_MODE,
  input wire logic [1:0] O_POWER,
  input wire logic O_COMP_INTERNAL,
  input wire logic O_CONVERTING
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge I_CLOCK);
  endclocking
  default disable iff (I_RESET);
  logic hard_off;
  assign hard_off = hard_shutdown_input_oe && !hard_shutdown_input;
  ////////////////////////////////////////////////////////////////////////////////////////////
  hard_shutdown_input_abort_a: assert property (hard_off |-> ##[1:8] (!O_CONVERTING && O_POWER == 2'h2))
    else $error("conversion not aborted by shutdown");
  hard_shutdown_input_mode_a: assert property (hard_off [*8] |-> O_MODE == 2'h0 && O_POWER == 2'h2)
    else $error("shutdown did not force deep sleep");
  comp_internal_a: assert property ((hard_shutdown_input_oe && hard_shutdown_input) [*8] |-> O_COMP_INTERNAL)
    else $error("driven high shutdown pin not internal compensation");
  comp_external_a: assert property ((!hard_shutdown_input_oe) [*8] |-> !O_COMP_INTERNAL)
    else $error("floating shutdown pin not external compensation");
  pins_release_a: assert property (hard_off [*8] |-> !conversion_strobe_output_oe && !dout_oe)
    else $error("outputs still driven in hard shutdown");
  sleep_idle_a: assert property (disable iff (I_RESET || hard_off)
    O_CONVERTING |-> O_POWER == 2'h0)
    else $error("conversion running while asleep");
  conv_start_a: assert property ($rose(O_CONVERTING) |-> !cs_n && !sclk)
    else $error("conversion began outside a low serial clock phase");
  int_hold_a: assert property (disable iff (I_RESET || hard_off)
    $rose(O_CONVERTING) && O_MODE == 2'h2 |-> O_CONVERTING [*8])
    else $error("internal conversion cut short");
  sleep_after_a: assert property (disable iff (I_RESET || hard_off)
    $fell(O_CONVERTING) && !O_MODE[1] |-> ##[0:4] O_POWER != 2'h0)
    else $error("no sleep after single conversion");
  stay_awake_a: assert property (disable iff (I_RESET || hard_off)
    $fell(O_CONVERTING) && O_MODE[1] |-> (O_POWER == 2'h0) [*4])
    else $error("slept although upper mode bit set");
  cover property ($rose(O_CONVERTING) && O_MODE == 2'h3);
  cover property ($rose(O_CONVERTING) && O_MODE == 2'h2);
  cover property (hard_off && O_CONVERTING);
endmodule

// >>> tb/tb.sv
// Self-checking bench: host end and converter end joined by the link interface.
// Assumes software access only through the host end's Avalon-MM port.
`define CHK(g, e) begin \
  n_tests++; \
  if ((g) !== (e)) begin \
    fails++; \
    $display("mismatch at %0t got %h expected %h", $time, (g), (e)); \
  end \
end
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [7:0] cmd; logic [11:0] code; logic [1:0] mode; logic [1:0] power;}
    adcpd_row_s;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [11:0] sample_code = 12'h000;
  logic [1:0] mode;
  logic [1:0] power;
  logic comp_internal;
  logic converting;
  logic [31:0] rd;
  int fails = 0;
  int n_tests = 0;
  int sclk_rises = 0;
  int n0;
  // Mode pair 11 twice, the others once; the rows after the deep and quick rows exercise wake-up by the start bit.
  adcpd_row_s rows [5] = '{'{8'h8f, 12'ha5c, 2'h3, 2'h0}, '{8'h8c, 12'h001, 2'h0, 2'h2},
    '{8'h8e, 12'hfff, 2'h2, 2'h0}, '{8'h8d, 12'h800, 2'h1, 2'h1},
    '{8'h8f, 12'h3c7, 2'h3, 2'h0}};
  adcpd_if link ();
  always #2.5 clock = ~clock;
  always @(posedge link.sclk) sclk_rises++;
  ////////////////////////////////////////////////////////////////////////////////////////////
  adcpd_device #(.INT_CONV_CYCLES(40)) i_adcpd_device (
    .I_CLOCK(clock), .I_RESET(reset), .LINK(link), .I_SAMPLE_CODE(sample_code),
    .O_MODE(mode), .O_POWER(power), .O_COMP_INTERNAL(comp_internal), .O_CONVERTING(converting)
  );
  adcpd_host #(.HALF_CYCLES(8), .WAKE_DEEP_CYCLES(50), .WAKE_EXT_CYCLES(50)) i_adcpd_host (
    .I_CLOCK(clock), .I_RESET(reset), .I_AVS_ADDRESS(avs_address), .I_AVS_READ(avs_read),
    .I_AVS_WRITE(avs_write), .I_AVS_WRITEDATA(avs_writedata), .O_AVS_READDATA(avs_readdata),
    .O_AVS_WAITREQUEST(avs_waitrequest), .LINK(link)
  );
  adcpd_properties i_adcpd_properties (
    .I_CLOCK(clock), .I_RESET(reset), .sclk(link.sclk), .cs_n(link.cs_n), .din(link.din),
    .hard_shutdown_input(link.hard_shutdown_input), .hard_shutdown_input_oe(link.hard_shutdown_input_oe), .dout(link.dout), .dout_oe(link.dout_oe),
    .conversion_strobe_output(link.conversion_strobe_output), .conversion_strobe_output_oe(link.conversion_strobe_output_oe), .O_MODE(mode), .O_POWER(power),
    .O_COMP_INTERNAL(comp_internal), .O_CONVERTING(converting)
  );
  ////////////////////////////////////////////////////////////////////////////////////////////
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge clock);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do @(posedge clock); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic wait_idle();
    do bus(1'b0, adcpd_pkg::REG_STATUS, 32'h0, rd); while (rd[adcpd_pkg::ST_BUSY_BIT] !== 1'b0);
  endtask
  task automatic convert(input logic [7:0] cmd, input logic [11:0] code);
    sample_code <= code;
    bus(1'b1, adcpd_pkg::REG_CMD, {24'h0, cmd}, rd);
    wait_idle();
    bus(1'b0, adcpd_pkg::REG_RESULT, 32'h0, rd);
  endtask
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // The whole sequence needs some 5500 cycles; the limit leaves wide margin.
  initial begin
    repeat (100000) @(posedge clock);
    fails++;
    complete_run();
  end
  ////////////////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(posedge clock);
    reset <= 1'b0;
    foreach (rows[i]) begin
      convert(rows[i].cmd, rows[i].code);
      `CHK(rd[11:0], rows[i].code)
      `CHK(mode, rows[i].mode)
      `CHK(power, rows[i].power)
      $display("test row %0d done", i);
    end
    // The last row woke from quick sleep, so the power-up wait is still running.
    bus(1'b0, adcpd_pkg::REG_STATUS, 32'h0, rd);
    `CHK(rd[adcpd_pkg::ST_SETTLED_BIT], 1'b0)
    repeat (adcpd_pkg::WAKE_QUICK_CYC) @(posedge clock);
    bus(1'b0, adcpd_pkg::REG_STATUS, 32'h0, rd);
    `CHK(rd[adcpd_pkg::ST_SETTLED_BIT], 1'b1)
    $display("test settle done");
    bus(1'b1, adcpd_pkg::REG_CFG, 32'h1, rd);
    repeat (10) @(posedge clock);
    `CHK(comp_internal, 1'b0)
    // Quick sleep with the pin floating adds the idle clocks after the frame.
    n0 = sclk_rises;
    convert(8'h8d, 12'h6b2);
    `CHK(rd[11:0], 12'h6b2)
    `CHK(mode, 2'h1)
    `CHK(power, 2'h1)
    `CHK(sclk_rises - n0, adcpd_pkg::FRAME_BITS + adcpd_pkg::IDLE_CLOCKS)
    bus(1'b1, adcpd_pkg::REG_CFG, 32'h2, rd);
    repeat (10) @(posedge clock);
    `CHK(comp_internal, 1'b1)
    $display("test compensation done");
    sample_code <= 12'h5a5;
    bus(1'b1, adcpd_pkg::REG_CMD, 32'h8f, rd);
    for (int i = 0; i < 2000 && converting !== 1'b1; i++) @(posedge clock);
    `CHK(converting, 1'b1)
    bus(1'b1, adcpd_pkg::REG_CFG, 32'h0, rd);
    repeat (10) @(posedge clock);
    `CHK(converting, 1'b0)
    `CHK(power, 2'h2)
    `CHK(mode, 2'h0)
    wait_idle();
    bus(1'b1, adcpd_pkg::REG_CFG, 32'h2, rd);
    repeat (60) @(posedge clock);
    `CHK(converting, 1'b0)
    convert(8'h8f, 12'h123);
    `CHK(rd[11:0], 12'h123)
    $display("test hard shutdown done");
    bus(1'b0, 4'h2, 32'h0, rd);
    `CHK(rd, 32'h0)
    bus(1'b1, adcpd_pkg::REG_RESULT, 32'hfff, rd);
    bus(1'b0, adcpd_pkg::REG_RESULT, 32'h0, rd);
    `CHK(rd[11:0], 12'h123)
    $display("test unmapped and read-only done");
    reset <= 1'b1;
    repeat (16) @(posedge clock);
    reset <= 1'b0;
    repeat (8) @(posedge clock);
    `CHK(mode, 2'h2)
    `CHK(power, 2'h0)
    `CHK(link.conversion_strobe_output, 1'b1)
    bus(1'b0, adcpd_pkg::REG_STATUS, 32'h0, rd);
    `CHK(rd[adcpd_pkg::ST_STROBE_BIT], 1'b1)
    $display("test reset done");
    complete_run();
  end
endmodule
